// ### hw/csu_pkg.sv
package csu_pkg;

  // ==========================================================
  // Register byte offsets on the APB
  // ==========================================================
  localparam logic [7:0] UPPER_SELECT_CTRL_OFF    = 8'h00;
  localparam logic [7:0] LOWER_SELECT_CTRL_OFF    = 8'h04;
  localparam logic [7:0] MID_BASE_CTRL_OFF        = 8'h08;
  localparam logic [7:0] PERIPH_BASE_CTRL_OFF     = 8'h0c;
  localparam logic [7:0] MID_PERIPH_SIZE_CTRL_OFF = 8'h10;
  localparam logic [7:0] PIN_CFG_OFF              = 8'h14;
  localparam logic [7:0] STATUS_OFF               = 8'h18;
  localparam logic [7:0] PCB_BASE_OFF             = 8'h1c;

  // ==========================================================
  // Field layout shared by the select control registers
  // ==========================================================
  localparam int WAIT_LSB  = 0;   // Wait-state code, bits 2:0.
  localparam int WAIT_W    = 3;
  localparam int READY_BIT = 3;   // External ready required.
  localparam int SUPP_BIT  = 7;   // Address suppress (upper and lower only).
  localparam int IOMEM_BIT = 8;   // Peripheral selects in memory space.
  localparam int AMODE_BIT = 9;   // Top peripheral pins carry latched A2 and A1.
  localparam int BND_LSB   = 16;  // Boundary address bits 19:10.
  localparam int BND_W     = 10;
  localparam int MSIZE_LSB = 20;  // Midrange block size code, bits 22:20.
  localparam int MSIZE_W   = 3;
  localparam int PCB_MEM_BIT = 12;
  localparam int PIN_PERIPH_LSB = 4;

  // ==========================================================
  // Reset values
  // ==========================================================
  // Upper window F0000h to FFFFFh, ready required, three waits.
  localparam logic [31:0] UPPER_RESET = 32'h03c0_000b;
  localparam logic [31:0] ZERO_RESET  = 32'h0000_0000;
  // Control block at FC00h in I/O space.
  localparam logic [31:0] PCB_RESET   = 32'h003f_0000;

  // ==========================================================
  // Select indices and decode constants
  // ==========================================================
  localparam int NSEL       = 14;
  localparam int SEL_UPPER  = 0;
  localparam int SEL_LOWER  = 1;
  localparam int SEL_MID0   = 2;
  localparam int SEL_PER0   = 6;
  localparam int SEL_PCB    = 13;
  localparam int NMID       = 4;
  localparam int NPER       = 7;
  localparam int HIDDEN_PER = 4;   // Fifth peripheral select has no pin.
  localparam logic [19:0] TOP_ADDR = 20'hfffff;
  localparam logic [19:0] MID_MIN_SIZE = 20'h02000;  // 8 Kbyte block at code 0.
  localparam logic [19:0] PER_SPAN = 20'h00100;      // 256 bytes per select.

  // A bus cycle as presented by the bus interface unit.
  typedef struct packed {
    logic [19:0] addr;
    logic        is_io;
  } csu_cycle_t;

  // Wait and ready policy of one select.
  typedef struct packed {
    logic [3:0] waits;
    logic       ready_req;
  } csu_policy_t;

  // Wait code to count; extended codes only for the lower five peripherals.
  function automatic logic [3:0] csu_waits(input logic [2:0] code, input logic ext);
    logic [3:0] w;
    w = {2'b00, code[1:0]};
    if (ext && code[2]) begin
      case (code[1:0])
        2'b00:   w = 4'h5;
        2'b01:   w = 4'h7;
        2'b10:   w = 4'h9;
        default: w = 4'hf;
      endcase
    end
    return w;
  endfunction

  // Policy taken from a control register.
  function automatic csu_policy_t csu_pol(input logic [31:0] r, input logic ext);
    csu_policy_t p;
    p.waits     = csu_waits(r[WAIT_LSB +: WAIT_W], ext);
    p.ready_req = r[READY_BIT];
    return p;
  endfunction

  // Inclusive range test.
  function automatic logic csu_in(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// ### hw/csu_wait_gen.sv
module csu_wait_gen
  import csu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  csu_pkg::csu_policy_t pol,
  input  wire logic        hang,
  input  wire logic        ready_in,
  output logic             busy,
  output logic             done
);
  import csu_pkg::*;

  typedef enum logic [2:0] {
    WG_IDLE  = 3'b001,
    WG_COUNT = 3'b010,
    WG_READY = 3'b100
  } csu_wg_state_t;

  csu_wg_state_t state_reg, state_next;
  logic [3:0]    cnt_reg, cnt_next;
  logic          rdy_reg, done_reg, done_next;

  // =========================================================
  // Wait counting and ready sampling
  // =========================================================
  // RULE_19: waits before ready
  // The programmed waits always finish before ready is looked at.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    done_next  = 1'b0;
    case (state_reg)
      WG_IDLE: begin
        if (start) begin
          cnt_next   = pol.waits;
          state_next = (pol.waits == 4'h0) ? WG_READY : WG_COUNT;
        end
      end
      WG_COUNT: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h1) begin
          state_next = WG_READY;
        end
      end
      WG_READY: begin
        // RULE_08: mismatch hang hazard
        // A mismatched overlap never ends, just like a missing ready.
        if (!hang && (!rdy_reg || ready_in)) begin
          done_next  = 1'b1;
          state_next = WG_IDLE;
        end
      end
      default: state_next = WG_IDLE;
    endcase
  end

  // Ready policy is latched at start so a register write cannot change it mid-cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= WG_IDLE;
      cnt_reg   <= 4'h0;
      rdy_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= done_next;
      if (start && state_reg == WG_IDLE) begin
        rdy_reg <= pol.ready_req;
      end
    end
  end

  assign busy = (state_reg != WG_IDLE);
  assign done = done_reg;

endmodule

// ### hw/csu_top.sv
// Operation
// RULE_01: software gives overlapping selects identical wait policy
// RULE_02: control block select: zero waits, no ready
// RULE_03: suppress bit blanks address on select hit
// RULE_04: mid/periph waits apply even as I/O pins
// RULE_05: access to base/size registers enables selects
// RULE_06: hidden fifth periph select keeps wait logic
// RULE_07: address-bit mode disables top periph waits
// RULE_08: mismatched overlap stalls cycle like missing ready
// RULE_09: I/O periph never overlaps memory selects
// RULE_10: upper select resets F0000h-FFFFFh, ready, three waits
// RULE_11: upper range always ends at FFFFFh
// RULE_12: lower select from 00000h, off until written
// RULE_13: midrange block relocatable, software avoids other regions
// RULE_14: mid/periph follow mux phase, upper/lower earlier
// RULE_15: periph selects decode memory or I/O space
// RULE_16: periph off at reset; wait code ranges
// RULE_17: each periph select spans 256 bytes
// RULE_18: CPU and DMA cycles decode alike
// RULE_19: programmed waits finish before ready sampled
// RULE_20: each control register has ready-required bit
// RULE_21: overlapped selects share one merged policy
//
// The APB register port and the register addresses were decided locally.
module csu_top
  import csu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cyc_start,
  input  csu_pkg::csu_cycle_t cyc,
  input  wire logic        async_ready_in,
  input  wire logic        sync_ready_in,
  output logic             cyc_done,
  output logic             cyc_busy,
  output logic             address_suppress_bit,
  output logic             upper_mem_select_n,
  output logic             lower_mem_select_n,
  output logic [3:0]       mid_mem_select_n,
  output logic [6:0]       periph_select_n,
  output logic [3:0]       mid_prog_io_pin,
  output logic [6:0]       periph_prog_io_pin,
  output logic             pcb_select
);
  import csu_pkg::*;

  // ==========================================================
  // Register storage
  // ==========================================================
  logic [31:0] upper_select_ctrl_reg, lower_select_ctrl_reg, mid_base_ctrl_reg;
  logic [31:0] periph_base_ctrl_reg, mid_periph_size_ctrl_reg, pin_cfg_reg;
  logic [31:0] pcb_base_reg;
  logic        lower_en_reg, mid_base_seen_reg, mid_size_seen_reg;
  logic        per_base_seen_reg, per_size_seen_reg;
  logic [31:0] prdata_reg;

  // ==========================================================
  // APB decode
  // ==========================================================
  wire         setup_ph  = psel && !penable;
  wire         access_ph = psel && penable;
  wire         wr_acc    = access_ph && pwrite;
  wire         hit_upper = (paddr == UPPER_SELECT_CTRL_OFF);
  wire         hit_lower = (paddr == LOWER_SELECT_CTRL_OFF);
  wire         hit_mbase = (paddr == MID_BASE_CTRL_OFF);
  wire         hit_pbase = (paddr == PERIPH_BASE_CTRL_OFF);
  wire         hit_size  = (paddr == MID_PERIPH_SIZE_CTRL_OFF);
  wire         hit_pin   = (paddr == PIN_CFG_OFF);
  wire         hit_stat  = (paddr == STATUS_OFF);
  wire         hit_pcb   = (paddr == PCB_BASE_OFF);
  wire         mapped    = hit_upper | hit_lower | hit_mbase | hit_pbase | hit_size
                           | hit_pin | hit_stat | hit_pcb;
  wire         mid_en    = mid_base_seen_reg && mid_size_seen_reg;
  wire         per_en    = per_base_seen_reg && per_size_seen_reg;
  wire         hang_flag;
  wire         wg_busy;
  logic [31:0] rd_mux;

  // Registers answer at once, so pready is always high.
  assign pready  = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata  = prdata_reg;

  // Read data is picked in setup so that it comes from a flip-flop in access.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit_upper: rd_mux = upper_select_ctrl_reg;
      hit_lower: rd_mux = lower_select_ctrl_reg;
      hit_mbase: rd_mux = mid_base_ctrl_reg;
      hit_pbase: rd_mux = periph_base_ctrl_reg;
      hit_size:  rd_mux = mid_periph_size_ctrl_reg;
      hit_pin:   rd_mux = pin_cfg_reg;
      hit_stat:  rd_mux = {26'h0, hang_flag, wg_busy, per_en, mid_en,
                           lower_en_reg, 1'b0};
      hit_pcb:   rd_mux = pcb_base_reg;
      default:   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= ZERO_RESET;
    end else if (setup_ph) begin
      prdata_reg <= rd_mux;
    end
  end

  // Register writes take effect only at the access edge.
  // RULE_10: upper reset window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_select_ctrl_reg    <= UPPER_RESET;
      lower_select_ctrl_reg    <= ZERO_RESET;
      mid_base_ctrl_reg        <= ZERO_RESET;
      periph_base_ctrl_reg     <= ZERO_RESET;
      mid_periph_size_ctrl_reg <= ZERO_RESET;
      pin_cfg_reg              <= ZERO_RESET;
      pcb_base_reg             <= PCB_RESET;
    end else if (wr_acc) begin
      if (hit_upper) upper_select_ctrl_reg <= pwdata;
      if (hit_lower) lower_select_ctrl_reg <= pwdata;
      if (hit_mbase) mid_base_ctrl_reg <= pwdata;
      if (hit_pbase) periph_base_ctrl_reg <= pwdata;
      if (hit_size)  mid_periph_size_ctrl_reg <= pwdata;
      if (hit_pin)   pin_cfg_reg <= pwdata;
      if (hit_pcb)   pcb_base_reg <= pwdata;
    end
  end

  // Enables are sticky; any read or write of the base and size registers arms them.
  // RULE_05: access arms selects
  // RULE_12: lower off until written
  // RULE_16: periph off at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_en_reg      <= 1'b0;
      mid_base_seen_reg <= 1'b0;
      mid_size_seen_reg <= 1'b0;
      per_base_seen_reg <= 1'b0;
      per_size_seen_reg <= 1'b0;
    end else if (access_ph) begin
      if (hit_lower && pwrite) lower_en_reg <= 1'b1;
      if (hit_mbase) mid_base_seen_reg <= 1'b1;
      if (hit_pbase) per_base_seen_reg <= 1'b1;
      if (hit_size) begin
        mid_size_seen_reg <= 1'b1;
        per_size_seen_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Address decode
  // ==========================================================
  wire [19:0] a       = cyc.addr;
  wire        mem_cyc = !cyc.is_io;
  // RULE_11: upper ends at top
  wire [19:0] up_lo   = {upper_select_ctrl_reg[BND_LSB +: BND_W], 10'h000};
  wire [19:0] lo_hi   = {lower_select_ctrl_reg[BND_LSB +: BND_W], 10'h3ff};
  wire [19:0] mid_lo  = {mid_base_ctrl_reg[BND_LSB +: BND_W], 10'h000};
  wire [19:0] mid_sz  = MID_MIN_SIZE << mid_periph_size_ctrl_reg[MSIZE_LSB +: MSIZE_W];
  wire [19:0] mid_q   = mid_sz >> 2;
  wire [19:0] per_lo  = {periph_base_ctrl_reg[BND_LSB +: BND_W], 10'h000};
  wire        per_mem = mid_periph_size_ctrl_reg[IOMEM_BIT];
  wire        amode   = mid_periph_size_ctrl_reg[AMODE_BIT];
  wire [19:0] pcb_lo  = {pcb_base_reg[BND_LSB +: BND_W], 10'h000};
  wire        pcb_mem = pcb_base_reg[PCB_MEM_BIT];
  logic [NSEL-1:0]  hit;
  csu_policy_t      pol [NSEL];

  // Memory selects only see memory cycles; I/O peripherals only I/O cycles.
  // RULE_18: CPU and DMA alike
  // RULE_09: I/O is separate
  always_comb begin
    hit[SEL_UPPER] = mem_cyc && csu_in(a, up_lo, TOP_ADDR);
    hit[SEL_LOWER] = mem_cyc && lower_en_reg && csu_in(a, 20'h00000, lo_hi);
    // RULE_13: relocatable midrange block
    for (int i = 0; i < NMID; i++) begin
      hit[SEL_MID0 + i] = mem_cyc && mid_en &&
                          csu_in(a, mid_lo + mid_q * 20'(i), mid_lo + mid_q * 20'(i + 1) - 20'h1);
    end
    // RULE_15: memory or I/O space
    // RULE_17: 256-byte spans
    for (int i = 0; i < NPER; i++) begin
      hit[SEL_PER0 + i] = per_en && (per_mem ? mem_cyc : cyc.is_io) &&
                          csu_in(a, per_lo + PER_SPAN * 20'(i),
                                 per_lo + PER_SPAN * 20'(i + 1) - 20'h1);
    end
    // RULE_07: address mode drops waits
    if (amode) begin
      hit[SEL_PER0 + 5] = 1'b0;
      hit[SEL_PER0 + 6] = 1'b0;
    end
    // RULE_02: internal control block
    hit[SEL_PCB] = (pcb_mem ? mem_cyc : cyc.is_io) &&
                   csu_in(a, pcb_lo, pcb_lo + PER_SPAN - 20'h1);
  end

  // Policy per select; the control block is fixed at zero waits, no ready.
  // RULE_20: ready bit per register
  // RULE_16: extended codes low four; the code gives them to the lower five
  // RULE_06: hidden select kept
  always_comb begin
    pol[SEL_UPPER] = csu_pol(upper_select_ctrl_reg, 1'b0);
    pol[SEL_LOWER] = csu_pol(lower_select_ctrl_reg, 1'b0);
    for (int i = 0; i < NMID; i++) begin
      pol[SEL_MID0 + i] = csu_pol(mid_base_ctrl_reg, 1'b0);
    end
    for (int i = 0; i < NPER; i++) begin
      pol[SEL_PER0 + i] = (i < 5) ? csu_pol(periph_base_ctrl_reg, 1'b1)
                                  : csu_pol(mid_periph_size_ctrl_reg, 1'b0);
    end
    pol[SEL_PCB] = '{waits: 4'h0, ready_req: 1'b0};
  end

  // ==========================================================
  // Overlap merge
  // ==========================================================
  // RULE_21: one merged policy
  // RULE_04: pin mode ignored here
  // The merge takes the longest wait and any ready demand; a disagreement
  // is flagged and becomes the hang described for mismatched overlaps.
  csu_policy_t merged;
  logic        mismatch;
  always_comb begin
    merged   = '{waits: 4'h0, ready_req: 1'b0};
    mismatch = 1'b0;
    for (int i = 0; i < NSEL; i++) begin
      if (hit[i]) begin
        if (pol[i].waits > merged.waits) merged.waits = pol[i].waits;
        merged.ready_req = merged.ready_req | pol[i].ready_req;
      end
    end
    // RULE_01: software keeps them equal
    for (int i = 0; i < NSEL; i++) begin
      if (hit[i] && (pol[i] != merged)) mismatch = 1'b1;
    end
  end

  // ==========================================================
  // Bus cycle sequencing
  // ==========================================================
  logic [NSEL-1:0] cyc_hit_reg;
  logic            mux_ph_reg, supp_reg, hang_reg, addr_a2_reg, addr_a1_reg;
  wire             take = cyc_start && !wg_busy;

  // RULE_03: suppress on upper/lower hit
  wire supp_next = (hit[SEL_UPPER] && upper_select_ctrl_reg[SUPP_BIT]) ||
                   (hit[SEL_LOWER] && lower_select_ctrl_reg[SUPP_BIT]);

  // Hits are held for the whole cycle and dropped when the cycle ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_hit_reg <= '0;
      mux_ph_reg  <= 1'b0;
      supp_reg    <= 1'b0;
      hang_reg    <= 1'b0;
      addr_a2_reg <= 1'b0;
      addr_a1_reg <= 1'b0;
    end else if (take) begin
      cyc_hit_reg <= hit;
      mux_ph_reg  <= 1'b0;
      supp_reg    <= supp_next;
      hang_reg    <= mismatch;
      addr_a2_reg <= a[2];
      addr_a1_reg <= a[1];
    end else if (cyc_done) begin
      cyc_hit_reg <= '0;
      mux_ph_reg  <= 1'b0;
      supp_reg    <= 1'b0;
    end else if (|cyc_hit_reg) begin
      mux_ph_reg  <= 1'b1;
    end
  end

  assign hang_flag = hang_reg && wg_busy;

  csu_wait_gen u_wait (
    .pclk     (pclk),
    .presetn  (presetn),
    .start    (take),
    .pol      (merged),
    .hang     (hang_reg),
    .ready_in (async_ready_in | sync_ready_in),
    .busy     (wg_busy),
    .done     (cyc_done)
  );

  // ==========================================================
  // Pin drive
  // ==========================================================
  // RULE_14: early and mux-phase selects
  // Upper, lower and the control block fire with the nonmultiplexed address; midrange and peripheral selects one cycle later.
  wire [3:0] mid_act = cyc_hit_reg[SEL_MID0 +: NMID] & {NMID{mux_ph_reg}};
  wire [6:0] per_act = cyc_hit_reg[SEL_PER0 +: NPER] & {NPER{mux_ph_reg}};
  wire [3:0] mid_pio = pin_cfg_reg[NMID-1:0];
  wire [6:0] per_pio = pin_cfg_reg[PIN_PERIPH_LSB +: NPER];

  assign cyc_busy             = wg_busy;
  assign address_suppress_bit = supp_reg;
  assign upper_mem_select_n   = !cyc_hit_reg[SEL_UPPER];
  assign lower_mem_select_n   = !cyc_hit_reg[SEL_LOWER];
  assign pcb_select           = cyc_hit_reg[SEL_PCB];
  // Pins in I/O mode stop showing the select, but their waits still count above.
  assign mid_mem_select_n     = ~(mid_act & ~mid_pio);
  assign mid_prog_io_pin      = mid_pio;
  assign periph_prog_io_pin   = per_pio;
  // The hidden select has no pin and always reads high.
  assign periph_select_n = {amode ? addr_a2_reg : !(per_act[6] && !per_pio[6]),
                            amode ? addr_a1_reg : !(per_act[5] && !per_pio[5]),
                            1'b1,
                            ~(per_act[3:0] & ~per_pio[3:0])};

endmodule

// ### verification/csu_properties.sv
// ==========================================
// Port checker for the chip-select unit
// ==========================================
module csu_properties (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic                cyc_start,
  input wire csu_pkg::csu_cycle_t cyc,
  input wire logic                cyc_busy,
  input wire logic                cyc_done,
  input wire logic                address_suppress_bit,
  input wire logic                upper_mem_select_n,
  input wire logic                lower_mem_select_n,
  input wire logic [3:0]          mid_mem_select_n,
  input wire logic [6:0]          periph_select_n,
  input wire logic                pcb_select
);
  timeunit 1ns;
  timeprecision 1ns;
  import csu_pkg::*;
  logic      lo_wr;
  wire logic take = cyc_start && !cyc_busy;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The lower select may only appear once software has written its control.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lo_wr <= 1'b0;
    else if (psel && penable && pwrite && paddr == LOWER_SELECT_CTRL_OFF) lo_wr <= 1'b1;
  end
  a_upper_at_top: assert property (
    take && !cyc.is_io && cyc.addr == TOP_ADDR |=> !upper_mem_select_n)
    else $error("upper select missed the top address");
  a_io_no_mem: assert property (
    take && cyc.is_io |=> upper_mem_select_n && lower_mem_select_n)
    else $error("memory select asserted in an I/O cycle");
  a_pcb_fast: assert property (take ##1 pcb_select |=> cyc_done)
    else $error("control block cycle was not zero wait");
  a_suppress_hit: assert property (
    address_suppress_bit |-> !(upper_mem_select_n && lower_mem_select_n))
    else $error("address suppressed without upper or lower hit");
  a_ul_early: assert property (
    $fell(upper_mem_select_n && lower_mem_select_n) |-> $past(take))
    else $error("upper or lower select late");
  a_mux_phase: assert property (
    $fell(&{mid_mem_select_n, periph_select_n[3:0]}) |-> $past(take, 2))
    else $error("mid or peripheral select not in mux phase");
  a_hidden_pin: assert property (periph_select_n[4])
    else $error("pinless peripheral select driven");
  a_lower_off: assert property (!lo_wr |-> lower_mem_select_n)
    else $error("lower select active before programming");
  a_done_pulse: assert property (cyc_done |=> !cyc_done)
    else $error("done held longer than one cycle");
  c_pcb: cover property (take ##1 pcb_select);
  c_supp: cover property (address_suppress_bit);
  c_mid: cover property ($fell(&mid_mem_select_n));
endmodule

bind csu_top csu_properties u_props (.*);

// ### verification/csu_mem_model.sv
// ==========================================
// External memory answering with ready
// ==========================================
module csu_mem_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       upper_mem_select_n,
  input  wire logic       lower_mem_select_n,
  input  wire logic [3:0] lag,
  output logic            async_ready_in,
  output logic            sync_ready_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  wire logic  sel = !(upper_mem_select_n && lower_mem_select_n);
  wire logic  rdy = sel && (cnt >= {1'b0, lag});
  // Count cycles selected; a deselected device never claims ready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 5'h00;
    else if (!sel) cnt <= 5'h00;
    else if (cnt != 5'h1f) cnt <= cnt + 5'h01;
  end
  // Odd lags answer on the asynchronous input, even ones on the synchronous.
  assign async_ready_in = rdy && lag[0];
  assign sync_ready_in  = rdy && !lag[0];
endmodule

// ### verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import csu_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, cyc_start, pready, pslverr, cyc_done, cyc_busy;
  logic address_suppress_bit, upper_mem_select_n, lower_mem_select_n, pcb_select, err;
  logic async_ready_in, sync_ready_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  mid_mem_select_n, mid_prog_io_pin, lag;
  logic [6:0]  periph_select_n, periph_prog_io_pin;
  logic [5:0]  seen;
  csu_cycle_t  cyc;
  int n, cycles = 0, bad_count = 0, n_checks = 0;
  int wt[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
  csu_top i_dut (.*);
  csu_mem_model i_mem (.*);
  always #25 pclk = ~pclk;
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Run one bus cycle; n is the cycle, counted from the start, that shows done.
  task automatic bus(input logic [19:0] a, input logic io);
    @(posedge pclk);
    cyc <= '{addr: a, is_io: io};
    cyc_start <= 1'b1;
    @(posedge pclk);
    cyc_start <= 1'b0;
    n = 0;
    seen = '0;
    do begin
      @(negedge pclk);
      n++;
      seen |= {address_suppress_bit, pcb_select, ~&{periph_select_n[6:5],
               periph_select_n[3:0]}, ~&mid_mem_select_n, ~lower_mem_select_n,
               ~upper_mem_select_n};
    end while (cyc_done !== 1'b1 && n < 40);
  endtask
  task automatic rst;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // A run still going after 4000 clock cycles ends as a failure.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      close_out();
    end
  end
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    {presetn, psel, penable, pwrite, cyc_start, paddr, pwdata, cyc, lag} = '0;
    rst();
    apb(0, UPPER_SELECT_CTRL_OFF, 0);
    chk(rd, UPPER_RESET);
    apb(0, LOWER_SELECT_CTRL_OFF, 0);
    chk(rd, ZERO_RESET);
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 32'h1);
    lag <= 4'h1;
    bus(20'hfffff, 0);
    chk(n, 5);
    chk(seen, 6'b000001);
    lag <= 4'h6;
    bus(20'hf0000, 0);
    chk(n, 8);
    $display("test reset defaults done");
    // Move the upper floor, then let upper cover everything.
    apb(1, UPPER_SELECT_CTRL_OFF, 32'h0380_0001);
    bus(20'he0000, 0);
    chk(n, 3);
    apb(1, UPPER_SELECT_CTRL_OFF, 32'h0);
    bus(20'h00000, 0);
    chk(seen, 6'b000001);
    apb(1, LOWER_SELECT_CTRL_OFF, 32'h80);
    bus(20'h00000, 0);
    chk(n, 2);
    chk(seen, 6'b100011);
    apb(1, LOWER_SELECT_CTRL_OFF, 32'h1);
    bus(20'h00000, 0);
    chk(n, 40);
    apb(0, STATUS_OFF, 0);
    chk({rd[5:0], cyc_busy}, 7'h65);
    presetn <= 1'b0;
    rst();
    apb(0, UPPER_SELECT_CTRL_OFF, 0);
    chk(rd, UPPER_RESET);
    $display("test overlap and hang done");
    // Midrange block at 40000h, pins first as I/O, then as selects.
    apb(1, PIN_CFG_OFF, 32'hf);
    apb(1, MID_BASE_CTRL_OFF, 32'h0100_0002);
    apb(0, MID_PERIPH_SIZE_CTRL_OFF, 0);
    chk({periph_prog_io_pin, mid_prog_io_pin}, 11'h00f);
    bus(20'h40000, 0);
    chk(n, 4);
    apb(1, PIN_CFG_OFF, 0);
    bus(20'h41fff, 0);
    chk(n, 4);
    chk(seen, 6'b000100);
    $display("test midrange done");
    // Peripheral block in I/O space at 0, lower at memory 0 with other timing.
    apb(1, LOWER_SELECT_CTRL_OFF, 32'hb);
    apb(1, MID_PERIPH_SIZE_CTRL_OFF, 32'h6);
    for (int c = 0; c < 8; c++) begin
      apb(1, PERIPH_BASE_CTRL_OFF, c);
      bus(20'h00000, 1);
      chk(n, wt[c] + 2);
    end
    chk(seen, 6'b001000);
    bus(20'h00400, 1);
    chk(n, 17);
    chk(seen, 6'b000000);
    bus(20'h005ff, 1);
    chk(n, 4);
    bus(20'h0fc00, 1);
    chk(seen, 6'b010000);
    apb(1, MID_PERIPH_SIZE_CTRL_OFF, 32'h106);
    bus(20'h00600, 0);
    chk(n, 4);
    chk(seen, 6'b001000);
    apb(1, MID_PERIPH_SIZE_CTRL_OFF, 32'h206);
    bus(20'h005fe, 1);
    chk(n, 2);
    chk(periph_select_n[6:5], 2'b11);
    $display("test peripheral and control block done");
    close_out();
  end
endmodule
